// ==== lif_line_interface.v ====
/*
 line interface mode and coding: transmit coder, receive slicer and decoder,
 strap-selected pin or serial-register configuration.
 assumes all inputs synchronous to clk; one line bit spans two clk cycles;
 the analog slicer and driver sit outside on the line pins.
*/
`default_nettype none
`include "lif_consts.vh"

module lif_line_interface (
	input  wire       clk,               // 10 MHz system clock
	input  wire       nrst,              // sync reset, low active
	input  wire       configSourceStrap, // high host, low hardware
	input  wire       txPosData,         // terminal data or positive rail
	input  wire       txNegData,         // terminal negative rail
	input  wire       txDataValid,       // terminal word offered
	output wire       txDataReady,       // fifo has room
	output wire       lineDrivePlus,     // positive pulse to line
	output wire       lineDriveMinus,    // negative pulse to line
	input  wire       lineSlicePlus,     // slicer positive comparator
	input  wire       lineSliceMinus,    // slicer negative comparator
	output wire       rxPositiveRail,    // recovered positive data
	output wire       rxNegativeRail,    // recovered negative data
	output wire       firstRxClock,      // recovered clock
	input  wire       txAmplitudePin,    // level pin
	input  wire       txAllOnesPin,      // all-ones pin
	input  wire       rxEqBypassPin,     // equalizer disable pin
	input  wire       localLoopPin,      // local loopback pin
	input  wire       remoteLoopPin,     // remote loopback pin
	input  wire       rateSts1Pin,       // sts-1/ds3 pin
	input  wire       rateE3Pin,         // e3 pin
	input  wire       txShutdownPin,     // driver off pin
	input  wire       registerClearInN,  // reg clear, or clk2 invert
	input  wire       serialInLine,      // serial data, or mute enable
	input  wire       serialClock,       // serial clock, or encoder bypass
	input  wire       chipSelectN,       // chip select, or decoder bypass
	output wire       serialOutLine,     // serial data, or violation flag
	output wire       serialOutEnable,   // high while driving serial out
	output wire       violationPinOut,   // violation flag, or second clock
	output wire       txAmplitudeSelect, // to pulse shaper
	output wire       txClockInvert,     // to transmit clock stage
	output wire       rxEqualizerBypass, // to equalizer
	output wire       rateSts1,          // to clock recovery
	output wire       rateE3,            // to clock recovery
	output wire       signalLoss         // loss of signal state
);

	reg        hostMode_reg;
	reg  [4:0] txCfg_reg;
	reg  [4:0] rxCfg_reg;
	reg  [4:0] rateCfg_reg;
	reg        sclkPrev_reg;
	reg  [3:0] bitCnt_reg;
	reg  [4:0] shift_reg;
	reg        isRead_reg;
	reg  [4:0] readWord_reg;
	reg        sdo_reg;
	reg        sdoEn_reg;
	reg        txPhase_reg;
	reg  [3:0] encMark_reg;
	reg  [3:0] encViol_reg;
	reg  [2:0] encZeros_reg;
	reg        encOdd_reg;
	reg        txPol_reg;
	reg        linePlus_reg;
	reg        lineMinus_reg;
	reg        rxPhase_reg;
	reg        slicePrev_reg;
	reg  [3:0] decPos_reg;
	reg  [3:0] decNeg_reg;
	reg        rxPol_reg;
	reg        rxVPol_reg;
	reg  [2:0] rxZeros_reg;
	reg  [7:0] losCnt_reg;
	reg        rxPos_reg;
	reg        rxNeg_reg;
	reg        rxClk1_reg;
	reg        lcv_reg;
	reg  [2:0] wrAddr_reg;
	reg  [3:0] encMark_next;
	reg  [3:0] encViol_next;
	reg  [3:0] decPos_next;
	reg  [3:0] decNeg_next;
	reg  [4:0] rdMux;
	wire       sclkRise;
	wire       sclkFall;
	wire       serialActive;
	wire       regClear;
	wire       txBinary;
	wire       txAllOnes;
	wire       tx_driver_shutdown;
	wire       encBypass;
	wire       decBypass;
	wire       muteEn;
	wire       clk2Inv;
	wire       localLoop;
	wire       remoteLoop;
	wire       hdb3;
	wire       fifoValid;
	wire [1:0] fifoData;
	wire       bitStrobe;
	wire       srcPos;
	wire       srcNeg;
	wire       srcMark;
	wire       subst;
	wire       inPlus;
	wire       inMinus;
	wire       symPlus;
	wire       symMinus;
	wire       symMark;
	wire       markStart;
	wire       rxSample;
	wire       violation;
	wire       zeroLimit;

	always @(posedge clk) begin
		if (!nrst) begin
			hostMode_reg <= configSourceStrap;
		end
	end

	assign txBinary   = hostMode_reg & txCfg_reg[`LIF_TX_BINARY];
	assign txAllOnes  = hostMode_reg ? txCfg_reg[`LIF_TX_ALLONES] : txAllOnesPin;
	assign tx_driver_shutdown      = hostMode_reg ? txCfg_reg[`LIF_TX_OFF] : txShutdownPin;
	assign encBypass  = hostMode_reg ? rxCfg_reg[`LIF_RX_ENCBYP] : serialClock;
	assign decBypass  = hostMode_reg ? rxCfg_reg[`LIF_RX_DECBYP] : chipSelectN;
	assign muteEn     = hostMode_reg ? rxCfg_reg[`LIF_RX_MUTE] : serialInLine;
	assign clk2Inv    = hostMode_reg ? rxCfg_reg[`LIF_RX_CLK2INV] : registerClearInN;
	assign localLoop  = hostMode_reg ? rateCfg_reg[`LIF_RT_LLB] : localLoopPin;
	assign remoteLoop = hostMode_reg ? rateCfg_reg[`LIF_RT_RLB] : remoteLoopPin;
	assign txAmplitudeSelect = hostMode_reg ? txCfg_reg[`LIF_TX_LEVEL] : txAmplitudePin;
	assign txClockInvert     = hostMode_reg & txCfg_reg[`LIF_TX_CLKINV];
	assign rxEqualizerBypass = hostMode_reg ? rxCfg_reg[`LIF_RX_EQBYP] : rxEqBypassPin;
	assign rateE3   = hostMode_reg ? rateCfg_reg[`LIF_RT_E3] : rateE3Pin;
	assign rateSts1 = ~rateE3 & (hostMode_reg ? rateCfg_reg[`LIF_RT_STS1] : rateSts1Pin);
	assign hdb3 = rateE3;

	// serial port edges, only in host mode with chip select low
	assign serialActive = hostMode_reg & ~chipSelectN;
	assign sclkRise     = serialActive & serialClock & ~sclkPrev_reg;
	assign sclkFall     = serialActive & ~serialClock & sclkPrev_reg;
	assign regClear     = hostMode_reg & ~registerClearInN;

	// read data select
	always @* begin
		rdMux = 5'h00;
		if ({shift_reg[1:0], serialInLine} == `LIF_IDX_TXCFG) begin
			rdMux = txCfg_reg;
		end else if ({shift_reg[1:0], serialInLine} == `LIF_IDX_RXCFG) begin
			rdMux = rxCfg_reg;
		end else if ({shift_reg[1:0], serialInLine} == `LIF_IDX_RATE) begin
			rdMux = rateCfg_reg;
		end else if ({shift_reg[1:0], serialInLine} == `LIF_IDX_STATUS) begin
			rdMux = {3'h0, signalLoss, lcv_reg};
		end
	end

	// serial frame engine and command registers
	always @(posedge clk) begin
		if (!nrst) begin
			sclkPrev_reg <= 1'b0;
			bitCnt_reg   <= 4'h0;
			shift_reg    <= 5'h00;
			isRead_reg   <= 1'b0;
			readWord_reg <= 5'h00;
			sdo_reg      <= 1'b0;
			sdoEn_reg    <= 1'b0;
			txCfg_reg    <= `LIF_CFG_RESET;
			rxCfg_reg    <= `LIF_CFG_RESET;
			rateCfg_reg  <= `LIF_CFG_RESET;
		end else begin
			sclkPrev_reg <= serialClock;
			if (regClear) begin
				txCfg_reg   <= `LIF_CFG_RESET;
				rxCfg_reg   <= `LIF_CFG_RESET;
				rateCfg_reg <= `LIF_CFG_RESET;
			end
			if (!serialActive) begin
				bitCnt_reg <= 4'h0;
				sdoEn_reg  <= 1'b0;
			end else if (sclkRise && bitCnt_reg != `LIF_FRAME_BITS) begin
				shift_reg  <= {shift_reg[3:0], serialInLine};
				bitCnt_reg <= bitCnt_reg + 4'h1;
				if (bitCnt_reg == 4'h0) begin
					isRead_reg <= serialInLine;
				end
				if (bitCnt_reg == `LIF_HDR_BITS - 4'h1) begin
					readWord_reg <= rdMux;
				end
				// write lands on the ninth rise, status stays read only
				if (bitCnt_reg == `LIF_FRAME_BITS - 4'h1 && !isRead_reg && !regClear) begin
					if (wrAddr_reg == `LIF_IDX_TXCFG) begin
						txCfg_reg <= {shift_reg[3:0], serialInLine};
					end else if (wrAddr_reg == `LIF_IDX_RXCFG) begin
						rxCfg_reg <= {shift_reg[3:0], serialInLine};
					end else if (wrAddr_reg == `LIF_IDX_RATE) begin
						rateCfg_reg <= {shift_reg[3:0], serialInLine};
					end
				end
			end else if (sclkFall && isRead_reg) begin
				if (bitCnt_reg >= `LIF_HDR_BITS && bitCnt_reg < `LIF_FRAME_BITS) begin
					sdo_reg      <= readWord_reg[4];
					readWord_reg <= {readWord_reg[3:0], 1'b0};
					sdoEn_reg    <= 1'b1;
				end else if (bitCnt_reg == `LIF_FRAME_BITS) begin
					sdoEn_reg <= 1'b0;
				end
			end
		end
	end

	// write address caught on the fourth rise of the header
	always @(posedge clk) begin
		if (!nrst) begin
			wrAddr_reg <= 3'h0;
		end else if (sclkRise && bitCnt_reg == `LIF_HDR_BITS - 4'h1) begin
			wrAddr_reg <= {shift_reg[1:0], serialInLine};
		end
	end

	// serial pins in their alternate roles
	assign serialOutLine   = hostMode_reg ? sdo_reg : lcv_reg;
	assign serialOutEnable = hostMode_reg ? sdoEn_reg : 1'b1;
	assign violationPinOut = hostMode_reg ? lcv_reg : (rxClk1_reg ^ clk2Inv);

	// transmit source, fifo in the data path
	lif_fifo #(
		.WIDTH (`LIF_FIFO_WIDTH),
		.DEPTH (`LIF_FIFO_DEPTH),
		.AW    (`LIF_FIFO_AW)
	) txFifo (
		.clk      (clk),
		.nrst     (nrst),
		.inData   ({txPosData, txNegData}),
		.inValid  (txDataValid),
		.inReady  (txDataReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (bitStrobe & ~txAllOnes & ~remoteLoop)
	);

	assign bitStrobe = ~txPhase_reg;
	// single rail ignores the negative rail
	assign srcPos  = txAllOnes | (remoteLoop ? rxPos_reg : (fifoValid & fifoData[1]));
	assign srcNeg  = ~txAllOnes & ~txBinary & (remoteLoop ? rxNeg_reg : (fifoValid & fifoData[0]));
	assign srcMark = srcPos | srcNeg;
	// substitution on the third or fourth zero
	assign subst = ~encBypass & ~srcMark & (encZeros_reg == (hdb3 ? `LIF_HDB3_ZEROS : `LIF_B3ZS_ZEROS));

	// encoder window update
	always @* begin
		encMark_next = {encMark_reg[2:0], srcMark | subst};
		encViol_next = {encViol_reg[2:0], subst};
		if (subst && !encOdd_reg) begin
			// hdb3 puts the b pulse three zeros back, b3zs two
			if (hdb3) begin
				encMark_next[3] = 1'b1;
			end else begin
				encMark_next[2] = 1'b1;
			end
		end
	end

	// encoder state and line drive
	always @(posedge clk) begin
		if (!nrst) begin
			txPhase_reg   <= 1'b0;
			encMark_reg   <= 4'h0;
			encViol_reg   <= 4'h0;
			encZeros_reg  <= 3'h0;
			encOdd_reg    <= 1'b0;
			txPol_reg     <= 1'b0;
			linePlus_reg  <= 1'b0;
			lineMinus_reg <= 1'b0;
		end else begin
			txPhase_reg <= ~txPhase_reg;
			if (bitStrobe) begin
				encMark_reg  <= encMark_next;
				encViol_reg  <= encViol_next;
				encZeros_reg <= (srcMark | subst) ? 3'h0 : encZeros_reg + 3'h1;
				encOdd_reg   <= subst ? 1'b0 : (encOdd_reg ^ srcMark);
				// one pulse per mark, none for a space
				if (encMark_reg[3] && !tx_driver_shutdown) begin
					if (encBypass && !txBinary) begin
						linePlus_reg  <= fifoValid & fifoData[1];
						lineMinus_reg <= fifoValid & fifoData[0] & ~fifoData[1];
					end else begin
						linePlus_reg  <= encViol_reg[3] ? txPol_reg : ~txPol_reg;
						lineMinus_reg <= encViol_reg[3] ? ~txPol_reg : txPol_reg;
					end
					if (!encViol_reg[3]) begin
						txPol_reg <= ~txPol_reg;
					end
				end else begin
					linePlus_reg  <= 1'b0;
					lineMinus_reg <= 1'b0;
				end
			end else begin
				// return to zero in the second half bit
				linePlus_reg  <= 1'b0;
				lineMinus_reg <= 1'b0;
			end
		end
	end

	assign lineDrivePlus  = linePlus_reg;
	assign lineDriveMinus = lineMinus_reg;

	// slicing into plus, minus or zero
	assign inPlus    = localLoop ? linePlus_reg : lineSlicePlus;
	assign inMinus   = localLoop ? lineMinus_reg : lineSliceMinus;
	assign symPlus   = inPlus & ~inMinus;
	assign symMinus  = inMinus & ~inPlus;
	assign symMark   = symPlus | symMinus;
	assign markStart = symMark & ~slicePrev_reg;
	assign rxSample  = markStart | (~rxPhase_reg & ~slicePrev_reg);
	assign violation = symMark & (symPlus == rxPol_reg);
	assign zeroLimit = ~symMark & (rxZeros_reg == (hdb3 ? `LIF_HDB3_ZEROS : `LIF_B3ZS_ZEROS));

	// decoder window, substitution removed on a violation
	always @* begin
		decPos_next = {decPos_reg[2:0], symPlus};
		decNeg_next = {decNeg_reg[2:0], symMinus};
		if (violation && !decBypass) begin
			decPos_next[0] = 1'b0;
			decNeg_next[0] = 1'b0;
			decPos_next[1] = 1'b0;
			decNeg_next[1] = 1'b0;
			decPos_next[2] = 1'b0;
			decNeg_next[2] = 1'b0;
			if (hdb3) begin
				decPos_next[3] = 1'b0;
				decNeg_next[3] = 1'b0;
			end
		end
	end

	// receive state and terminal outputs
	always @(posedge clk) begin
		if (!nrst) begin
			rxPhase_reg   <= 1'b0;
			slicePrev_reg <= 1'b0;
			decPos_reg    <= 4'h0;
			decNeg_reg    <= 4'h0;
			rxPol_reg     <= 1'b0;
			rxVPol_reg    <= 1'b0;
			rxZeros_reg   <= 3'h0;
			losCnt_reg    <= 8'h00;
			rxPos_reg     <= 1'b0;
			rxNeg_reg     <= 1'b0;
			rxClk1_reg    <= 1'b0;
			lcv_reg       <= 1'b0;
		end else begin
			slicePrev_reg <= symMark;
			rxPhase_reg   <= rxSample;
			rxClk1_reg    <= rxSample;
			if (rxSample) begin
				decPos_reg  <= decPos_next;
				decNeg_reg  <= decNeg_next;
				rxZeros_reg <= symMark ? 3'h0 : (zeroLimit ? rxZeros_reg : rxZeros_reg + 3'h1);
				losCnt_reg  <= symMark ? 8'h00 : (signalLoss ? losCnt_reg : losCnt_reg + 8'h01);
				if (symMark) begin
					rxPol_reg <= symPlus;
				end
				if (violation) begin
					rxVPol_reg <= symPlus;
				end
				// bad violation polarity or too many zeros
				lcv_reg <= (violation & (symPlus == rxVPol_reg)) | (zeroLimit & ~decBypass);
				// rails toward terminal, muted on signal loss
				rxPos_reg <= decPos_reg[3] & ~(signalLoss & muteEn);
				rxNeg_reg <= decNeg_reg[3] & ~(signalLoss & muteEn);
			end
		end
	end

	assign signalLoss     = (losCnt_reg == `LIF_LOS_ZEROS);
	assign rxPositiveRail = rxPos_reg;
	assign rxNegativeRail = rxNeg_reg;
	assign firstRxClock   = rxClk1_reg;

endmodule

`default_nettype wire

// ==== lif_consts.vh ====
/*
 constants for the line interface mode and coding block: command register
 indices, field positions, reset values and line timing counts.
 assumes it is included by its bare name by the line interface module.
*/
`ifndef LIF_CONSTS_VH
`define LIF_CONSTS_VH

// serial frame layout: rw bit, three address bits, five data bits
`define LIF_FRAME_BITS   4'h9
`define LIF_HDR_BITS     4'h4

// command register indices
`define LIF_IDX_TXCFG    3'h1
`define LIF_IDX_RXCFG    3'h2
`define LIF_IDX_RATE     3'h4
`define LIF_IDX_STATUS   3'h5

// transmit config fields
`define LIF_TX_BINARY    0
`define LIF_TX_LEVEL     1
`define LIF_TX_CLKINV    2
`define LIF_TX_ALLONES   3
`define LIF_TX_OFF       4

// receive config fields
`define LIF_RX_EQBYP     0
`define LIF_RX_ENCBYP    1
`define LIF_RX_DECBYP    2
`define LIF_RX_MUTE      3
`define LIF_RX_CLK2INV   4

// rate and loopback fields
`define LIF_RT_RLB       0
`define LIF_RT_LLB       1
`define LIF_RT_E3        2
`define LIF_RT_STS1      3

// reset values
`define LIF_CFG_RESET    5'h00

// zero runs allowed by each code before a violation is flagged
`define LIF_B3ZS_ZEROS   3'h2
`define LIF_HDB3_ZEROS   3'h3

// zero symbols in a row that declare loss of signal
`define LIF_LOS_ZEROS    8'h20

// fifo shape
`define LIF_FIFO_WIDTH   2
`define LIF_FIFO_DEPTH   16
`define LIF_FIFO_AW      4

`endif

// ==== lif_fifo.v ====
/*
 small synchronous fifo with a registered read stage.
 assumes one clock, synchronous active-low reset, valid/ready on both sides.
*/
`default_nettype none

module lif_fifo #(
	parameter WIDTH = 2,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,      // system clock
	input  wire             nrst,     // sync reset, low active
	input  wire [WIDTH-1:0] inData,   // write data
	input  wire             inValid,  // write request
	output wire             inReady,  // space free
	output wire [WIDTH-1:0] outData,  // registered read data
	output wire             outValid, // read data present
	input  wire             outReady  // reader takes word
);

	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wrPtr_reg;
	reg  [AW-1:0]    rdPtr_reg;
	reg  [AW:0]      count_reg;
	reg  [WIDTH-1:0] outData_reg;
	reg              outValid_reg;
	wire             push;
	wire             load;
	wire             memEmpty;

	// handshake terms
	assign memEmpty = (count_reg == {(AW+1){1'b0}});
	assign inReady  = (count_reg != DEPTH[AW:0]);
	assign push     = inValid & inReady;
	assign load     = ~memEmpty & (~outValid_reg | outReady);
	assign outData  = outData_reg;
	assign outValid = outValid_reg;

	// storage array
	always @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	// pointers, count and read stage
	always @(posedge clk) begin
		if (!nrst) begin
			wrPtr_reg    <= {AW{1'b0}};
			rdPtr_reg    <= {AW{1'b0}};
			count_reg    <= {(AW+1){1'b0}};
			outData_reg  <= {WIDTH{1'b0}};
			outValid_reg <= 1'b0;
		end else begin
			if (push) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (load) begin
				rdPtr_reg   <= rdPtr_reg + 1'b1;
				outData_reg <= mem[rdPtr_reg];
			end
			if (push & ~load) begin
				count_reg <= count_reg + 1'b1;
			end else if (load & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
			if (load) begin
				outValid_reg <= 1'b1;
			end else if (outReady) begin
				outValid_reg <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ==== lif_host_model.sv ====
/*
 host serial controller model: drives the four-wire port and gathers read bits.
 assumes the block samples the serial lines on clk and launches read bits after falls.
*/
`default_nettype none
module lif_host_model (
	input  wire logic clk,             // system clock
	output var  logic serialClock,     // serial clock to block
	output var  logic serialInLine,    // serial data to block
	output var  logic chipSelectN,     // chip select, low active
	input  wire logic serialOutLine,   // serial data from block
	input  wire logic serialOutEnable  // block drives serial out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lastBit = 1'b0;
	// idle: deselected, clock low
	initial begin
		serialClock = 1'b0;
		serialInLine = 1'b0;
		chipSelectN = 1'b1;
	end
	// one nine-bit frame; read bits taken just before each rise
	task automatic frame(input logic rw, input logic [2:0] adr, input logic [4:0] wd, output logic [4:0] rd);
		logic [8:0] word;
		logic seen;
		word = {rw, adr, wd};
		rd = 5'h00;
		@(negedge clk);
		chipSelectN = 1'b0;
		for (int i = 8; i >= 0; i--) begin
			serialInLine = word[i];
			repeat (2) @(negedge clk);
			// released line reads as inverse of last bit
			seen = serialOutEnable ? serialOutLine : ~lastBit;
			lastBit = seen;
			if (i < 5)
				rd[i] = seen;
			serialClock = 1'b1;
			repeat (3) @(negedge clk);
			serialClock = 1'b0;
		end
		repeat (3) @(negedge clk);
		chipSelectN = 1'b1;
		serialInLine = ~serialInLine;
		repeat (3) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ==== lif_line_interface_assertions.sv ====
/*
 port checks for the line interface mode and coding block.
 assumes clk with sync active-low nrst; the strap is caught while nrst is low.
*/
`default_nettype none
module lif_line_interface_assertions (
	input wire logic clk,               // system clock
	input wire logic nrst,              // sync reset, low active
	input wire logic configSourceStrap, // mode strap
	input wire logic lineDrivePlus,     // positive pulse
	input wire logic lineDriveMinus,    // negative pulse
	input wire logic firstRxClock,      // recovered clock
	input wire logic txAmplitudePin,    // level pin
	input wire logic rxEqBypassPin,     // equalizer pin
	input wire logic rateSts1Pin,       // sts-1 pin
	input wire logic rateE3Pin,         // e3 pin
	input wire logic registerClearInN,  // clear or clock invert
	input wire logic serialClock,       // serial clock
	input wire logic chipSelectN,       // chip select
	input wire logic serialOutLine,     // serial data out
	input wire logic serialOutEnable,   // serial out drive
	input wire logic violationPinOut,   // flag or second clock
	input wire logic txAmplitudeSelect, // effective level
	input wire logic rxEqualizerBypass, // effective eq bypass
	input wire logic rateSts1,          // effective sts-1
	input wire logic rateE3             // effective e3
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hostMode_reg;
	// mode strap caught while reset is held
	always_ff @(posedge clk) begin
		if (!nrst)
			hostMode_reg <= configSourceStrap;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	rate_e3_a: assert property (!hostMode_reg |-> rateE3 == rateE3Pin)
		else $error("e3 select does not follow pin");
	rate_sts_a: assert property (!hostMode_reg && !rateE3Pin |-> rateSts1 == rateSts1Pin)
		else $error("sts-1 select does not follow pin");
	hw_level_a: assert property (!hostMode_reg |-> txAmplitudeSelect == txAmplitudePin && rxEqualizerBypass == rxEqBypassPin)
		else $error("level or equalizer pin not honoured");
	clk2_role_a: assert property (!hostMode_reg |-> violationPinOut == (firstRxClock ^ registerClearInN))
		else $error("second clock pin wrong in pin mode");
	hw_drive_a: assert property (!hostMode_reg |-> serialOutEnable)
		else $error("flag pin not driven in pin mode");
	host_hold_a: assert property (hostMode_reg && $past(nrst) && chipSelectN && $past(chipSelectN) && registerClearInN
			&& $past(registerClearInN) |-> $stable(rateE3) && $stable(rateSts1) && $stable(txAmplitudeSelect))
		else $error("config moved without serial access");
	sdo_release_a: assert property (hostMode_reg && $rose(chipSelectN) |-> ##[0:2] !serialOutEnable)
		else $error("serial out not released");
	sdo_launch_a: assert property (hostMode_reg && serialOutEnable && $changed(serialOutLine) |-> !$past(serialClock))
		else $error("serial out moved while clock high");
	mark_polarity_a: assert property (!(lineDrivePlus && lineDriveMinus))
		else $error("both pulse polarities at once");
	mark_width_a: assert property (lineDrivePlus || lineDriveMinus |=> !lineDrivePlus && !lineDriveMinus)
		else $error("pulse longer than half a bit");
	cover property (hostMode_reg && serialOutEnable);
	cover property (lineDriveMinus);
	cover property (!hostMode_reg && violationPinOut);
endmodule
bind lif_line_interface lif_line_interface_assertions chk_u (.clk, .nrst, .configSourceStrap, .lineDrivePlus,
	.lineDriveMinus, .firstRxClock, .txAmplitudePin, .rxEqBypassPin, .rateSts1Pin, .rateE3Pin, .registerClearInN,
	.serialClock, .chipSelectN, .serialOutLine, .serialOutEnable, .violationPinOut, .txAmplitudeSelect,
	.rxEqualizerBypass, .rateSts1, .rateE3);
`default_nettype wire

// ==== test_lif_line_interface.sv ====
/*
 self-checking bench: pin mode rates and coding, receive strobes, host registers,
 transmit buffer and strap capture.
 assumes the checker binds itself and the host model drives the serial pins.
*/
`default_nettype none
module test_lif_line_interface;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic configSourceStrap = 1'b0;
	logic txPosData = 1'b0, txNegData = 1'b0, txDataValid = 1'b0, registerClearInN = 1'b1;
	logic lineSlicePlus = 1'b1, lineSliceMinus = 1'b1;
	logic txAmplitudePin = 1'b0, txAllOnesPin = 1'b0, rxEqBypassPin = 1'b0, localLoopPin = 1'b0;
	logic remoteLoopPin = 1'b0, rateSts1Pin = 1'b0, rateE3Pin = 1'b0, txShutdownPin = 1'b0;
	wire logic serialClock, serialInLine, chipSelectN, serialOutLine, serialOutEnable, txDataReady;
	wire logic lineDrivePlus, lineDriveMinus, firstRxClock, violationPinOut, signalLoss, rxPositiveRail, rxNegativeRail;
	wire logic txAmplitudeSelect, rxEqualizerBypass, rateSts1, rateE3;
	int failures = 0;
	int tests_run = 0;
	int plus, minus, n, rxp, rxn;
	logic [4:0] rd;
	logic [2:0] modes [5] = '{3'h0, 3'h4, 3'h6, 3'h2, 3'h1};
	int wantPulses [5] = '{32, 24, 24, 32, 0};
	// 10 MHz clock
	always #50 clk = ~clk;
	lif_line_interface dut_u (.clk, .nrst, .configSourceStrap, .txPosData, .txNegData, .txDataValid, .txDataReady,
		.lineDrivePlus, .lineDriveMinus, .lineSlicePlus, .lineSliceMinus, .rxPositiveRail, .rxNegativeRail,
		.firstRxClock, .txAmplitudePin, .txAllOnesPin, .rxEqBypassPin, .localLoopPin, .remoteLoopPin,
		.rateSts1Pin, .rateE3Pin, .txShutdownPin, .registerClearInN, .serialInLine, .serialClock, .chipSelectN,
		.serialOutLine, .serialOutEnable, .violationPinOut, .txAmplitudeSelect, .txClockInvert(),
		.rxEqualizerBypass, .rateSts1, .rateE3, .signalLoss);
	lif_host_model host_u (.clk, .serialClock, .serialInLine, .chipSelectN, .serialOutLine, .serialOutEnable);
	// compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			failures++;
			$display("mismatch at %0t ns: seen %0h expected %0h", $time, seen, want);
		end
	endtask
	// verdict and end of run
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// reset for five cycles with the strap set
	task automatic do_reset(input logic mode);
		@(negedge clk);
		nrst = 1'b0;
		configSourceStrap = mode;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
	endtask
	// pulses on the line over 48 bits after settling
	task automatic count_line(output int p, output int m);
		p = 0;
		m = 0;
		rxp = 0;
		rxn = 0;
		repeat (40) @(negedge clk);
		repeat (96) begin
			@(negedge clk);
			p += lineDrivePlus;
			m += lineDriveMinus;
			rxp += rxPositiveRail;
			rxn += rxNegativeRail;
		end
	endtask
	// hang guard
	initial begin
		#1_000_000;
		failures++;
		close_out();
	end
	// main sequence
	initial begin
		do_reset(1'b0);
		txAmplitudePin = 1'b1;
		rxEqBypassPin = 1'b1;
		registerClearInN = 1'b0;
		for (int k = 0; k < 5; k++) begin
			{rateE3Pin, rateSts1Pin, host_u.serialClock} = modes[k];
			count_line(plus, minus);
			check(8'(plus + minus), 8'(wantPulses[k]));
			check(8'(plus), 8'(wantPulses[k] / 2));
			check({6'h0, rateE3, rateSts1}, {6'h0, modes[k][2], modes[k][1] & ~modes[k][2]});
		end
		check({6'h0, txAmplitudeSelect, rxEqualizerBypass}, 8'h03);
		host_u.serialClock = 1'b0;
		n = 0;
		repeat (100) begin
			@(negedge clk);
			n += firstRxClock;
		end
		check(8'(n), 8'h32);
		check({7'h0, signalLoss}, 8'h01);
		$display("pin mode test done");
		do_reset(1'b1);
		registerClearInN = 1'b1;
		{txAmplitudePin, txAllOnesPin, rxEqBypassPin, localLoopPin} = 4'hf;
		{remoteLoopPin, rateSts1Pin, rateE3Pin, txShutdownPin} = 4'hf;
		// e3 with local loopback, read back
		host_u.frame(1'b0, 3'h4, 5'h06, rd);
		host_u.frame(1'b1, 3'h4, 5'h00, rd);
		check(8'(rd), 8'h06);
		check({4'h0, rateE3, rateSts1, txAmplitudeSelect, rxEqualizerBypass}, 8'h08);
		// board holds ignored pins low in host mode
		{txAmplitudePin, txAllOnesPin, rxEqBypassPin, localLoopPin} = 4'h0;
		{remoteLoopPin, rateSts1Pin, rateE3Pin, txShutdownPin} = 4'h0;
		host_u.frame(1'b1, 3'h3, 5'h00, rd);
		check(8'(rd), 8'h00);
		host_u.frame(1'b0, 3'h1, 5'h01, rd);
		txPosData = 1'b1;
		txDataValid = 1'b1;
		n = 0;
		while (txDataReady !== 1'b0 && n < 80) begin
			@(negedge clk);
			n++;
		end
		check({7'h0, txDataReady}, 8'h00);
		count_line(plus, minus);
		check(8'(plus), 8'h18);
		check(8'(minus), 8'h18);
		// looped ami marks come back on both rails
		check(8'(rxp), 8'h30);
		check(8'(rxn), 8'h30);
		txDataValid = 1'b0;
		repeat (60) @(negedge clk);
		check({7'h0, txDataReady}, 8'h01);
		// looped hdb3 zeros: substitutions on line, none on rails
		count_line(plus, minus);
		check(8'(plus + minus), 8'h18);
		check(8'(rxp + rxn), 8'h00);
		registerClearInN = 1'b0;
		repeat (3) @(negedge clk);
		registerClearInN = 1'b1;
		host_u.frame(1'b1, 3'h1, 5'h00, rd);
		check(8'(rd), 8'h00);
		configSourceStrap = 1'b0;
		repeat (4) @(negedge clk);
		check({7'h0, serialOutEnable}, 8'h00);
		$display("host mode test done");
		close_out();
	end
endmodule
`default_nettype wire
